// ---- hw/pcir_pkg.sv ----
package pcir_pkg;
  // register byte offsets on apb: printed offsets 0x87 and 0xb7 are not multiples of four,
  // so each printed offset is an index and the byte address is four times it
  localparam logic [7:0]  PCIR_IDX_POWER_CTRL  = 8'h87;
  localparam logic [7:0]  PCIR_IDX_PRIO_LOW    = 8'hb8;
  localparam logic [7:0]  PCIR_IDX_PRIO_HIGH   = 8'hb7;
  localparam logic [7:0]  PCIR_IDX_IRQ_STATUS  = 8'hc0;
  localparam logic [7:0]  PCIR_IDX_IRQ_MASK    = 8'hc1;
  localparam logic [7:0]  PCIR_IDX_SER_CTRL7   = 8'hc2;
  localparam logic [11:0] PCIR_ADDR_POWER_CTRL = {2'h0, PCIR_IDX_POWER_CTRL, 2'h0};
  localparam logic [11:0] PCIR_ADDR_PRIO_LOW   = {2'h0, PCIR_IDX_PRIO_LOW, 2'h0};
  localparam logic [11:0] PCIR_ADDR_PRIO_HIGH  = {2'h0, PCIR_IDX_PRIO_HIGH, 2'h0};
  localparam logic [11:0] PCIR_ADDR_IRQ_STATUS = {2'h0, PCIR_IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] PCIR_ADDR_IRQ_MASK   = {2'h0, PCIR_IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] PCIR_ADDR_SER_CTRL7  = {2'h0, PCIR_IDX_SER_CTRL7, 2'h0};
  // power control field positions
  localparam int PCIR_BIT_BAUD_DOUBLER   = 7;
  localparam int PCIR_BIT_FRAMING_VIEW   = 6;
  localparam int PCIR_BIT_POWER_OFF      = 4;
  localparam int PCIR_BIT_USER_FLAG_1    = 3;
  localparam int PCIR_BIT_USER_FLAG_0    = 2;
  localparam int PCIR_BIT_POWER_DOWN     = 1;
  localparam int PCIR_BIT_SLEEP          = 0;
  localparam logic [7:0] PCIR_PCTRL_WMASK = 8'hdf;
  localparam logic [7:0] PCIR_PRIO_WMASK  = 8'h3f;
  localparam logic [7:0] PCIR_PCTRL_RESET = 8'h10;
  localparam logic [7:0] PCIR_PRIO_RESET  = 8'h00;
  // irq status bit positions
  localparam int PCIR_IRQ_FRAMING  = 0;
  localparam int PCIR_IRQ_POWERDN  = 1;
  localparam int PCIR_IRQ_SLEEP    = 2;
  localparam int PCIR_IRQ_W        = 3;
  // value driven on the undefined bits; any value is legal there
  localparam logic PCIR_UNDEF_READ = 1'b0;
endpackage : pcir_pkg

// ---- hw/pcir_regs.sv ----
// The APB interface to the registers is this design's own decision.
module pcir_regs
  import pcir_pkg::*;
#(
  parameter int N_SRC = 6
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              cold_rst_n,
  input  wire logic              supply_up,
  input  wire logic              irq_taken,
  input  wire logic              stop_bit_bad,
  input  wire logic [1:0]        serial_mode,
  input  wire logic              serial_mode_bit0,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic                   baud_double_en,
  output logic                   framing_view_select,
  output logic                   framing_error_flag,
  output logic                   power_down_request,
  output logic                   sleep_request,
  output logic [2*N_SRC-1:0]     src_level,
  output logic                   irq
);

  if (N_SRC != 6) begin : g_bad_src
    $error("pcir_regs serves exactly six sources");
  end

  logic [7:0]          pctrl_q;
  logic                power_off_q;
  logic [7:0]          prio_low_q;
  logic [7:0]          prio_high_q;
  logic                fe_q;
  logic [PCIR_IRQ_W-1:0] irq_stat_q;
  logic [PCIR_IRQ_W-1:0] irq_mask_q;
  logic [7:0]          rdata_d;
  logic                hit;

  wire wr_en = psel && penable && pwrite && pstrb[0];
  // read data is latched in the setup cycle so the access phase needs no wait
  wire rd_setup = psel && !penable && !pwrite;

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction : is_reg

  wire wr_pctrl = wr_en && is_reg(paddr, PCIR_ADDR_POWER_CTRL);
  wire wr_low   = wr_en && is_reg(paddr, PCIR_ADDR_PRIO_LOW);
  wire wr_high  = wr_en && is_reg(paddr, PCIR_ADDR_PRIO_HIGH);
  wire wr_stat  = wr_en && is_reg(paddr, PCIR_ADDR_IRQ_STATUS);
  wire wr_mask  = wr_en && is_reg(paddr, PCIR_ADDR_IRQ_MASK);
  wire wr_ser7  = wr_en && is_reg(paddr, PCIR_ADDR_SER_CTRL7);
  wire [7:0] wd = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // power control bits other than the power-off flag, on warm reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pctrl_q <= PCIR_PCTRL_RESET & ~(8'h01 << PCIR_BIT_POWER_OFF);
    end else begin
      if (wr_pctrl) begin
        pctrl_q <= wd & PCIR_PCTRL_WMASK & ~(8'h01 << PCIR_BIT_POWER_OFF);
      end
      // wake on interrupt beats a same-cycle write of the sleep bit
      if (irq_taken) begin
        pctrl_q[PCIR_BIT_SLEEP] <= 1'b0;
      end
    end
  end

  // power-off flag lives on the cold reset only so warm resets keep it
  always_ff @(posedge ref_clk or negedge cold_rst_n) begin
    if (!cold_rst_n) begin
      power_off_q <= 1'b1;
    end else if (supply_up) begin
      power_off_q <= 1'b1;
    end else if (wr_pctrl) begin
      power_off_q <= wd[PCIR_BIT_POWER_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority registers, six valid bits each
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_low_q  <= PCIR_PRIO_RESET;
      prio_high_q <= PCIR_PRIO_RESET;
    end else begin
      if (wr_low)  prio_low_q  <= wd & PCIR_PRIO_WMASK;
      if (wr_high) prio_high_q <= wd & PCIR_PRIO_WMASK;
    end
  end

  // level {high,low}: numeric order puts 10 above 01
  always_comb begin
    for (int i = 0; i < N_SRC; i++) begin
      src_level[2*i+:2] = {prio_high_q[i], prio_low_q[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // framing error flag: set wins over software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fe_q <= 1'b0;
    end else if (stop_bit_bad) begin
      fe_q <= 1'b1;
    end else if (wr_ser7 && pctrl_q[PCIR_BIT_FRAMING_VIEW] && !wd[7]) begin
      fe_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, write one to clear, event wins
  wire [PCIR_IRQ_W-1:0] evt = {pctrl_q[PCIR_BIT_SLEEP] && irq_taken,
                               wr_pctrl && wd[PCIR_BIT_POWER_DOWN],
                               stop_bit_bad};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? wd[PCIR_IRQ_W-1:0] : '0)) | evt;
      if (wr_mask) irq_mask_q <= wd[PCIR_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; bit 7 view follows the select
  always_comb begin
    rdata_d = 8'h00;
    hit     = 1'b1;
    case (paddr)
      PCIR_ADDR_POWER_CTRL: begin
        rdata_d = pctrl_q;
        rdata_d[PCIR_BIT_POWER_OFF] = power_off_q;
        rdata_d[5] = PCIR_UNDEF_READ;
      end
      PCIR_ADDR_PRIO_LOW:   rdata_d = {PCIR_UNDEF_READ, PCIR_UNDEF_READ, prio_low_q[5:0]};
      PCIR_ADDR_PRIO_HIGH:  rdata_d = {PCIR_UNDEF_READ, PCIR_UNDEF_READ, prio_high_q[5:0]};
      PCIR_ADDR_IRQ_STATUS: rdata_d = {5'h00, irq_stat_q};
      PCIR_ADDR_IRQ_MASK:   rdata_d = {5'h00, irq_mask_q};
      PCIR_ADDR_SER_CTRL7:  rdata_d = {pctrl_q[PCIR_BIT_FRAMING_VIEW] ? fe_q : serial_mode_bit0, 7'h00};
      default: hit = 1'b0;
    endcase
  end

  // zero-wait slave; read data registered at the setup cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rdata_d};
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  assign baud_double_en      = pctrl_q[PCIR_BIT_BAUD_DOUBLER] && (serial_mode != 2'b00);
  assign framing_view_select = pctrl_q[PCIR_BIT_FRAMING_VIEW];
  assign framing_error_flag  = fe_q;
  assign power_down_request  = pctrl_q[PCIR_BIT_POWER_DOWN];
  assign sleep_request       = pctrl_q[PCIR_BIT_SLEEP];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_fe_sticky;
    @(posedge ref_clk) disable iff (!rst_n) stop_bit_bad |=> fe_q;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("framing flag not set");

  property p_fe_hold;
    @(posedge ref_clk) disable iff (!rst_n) (fe_q && !wr_ser7) |=> fe_q;
  endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("framing flag lost");

  property p_pof_up;
    @(posedge ref_clk) disable iff (!cold_rst_n) supply_up |=> power_off_q;
  endproperty
  a_pof_up: assert property (p_pof_up) else $error("power-off flag not set");

  property p_sleep_wake;
    @(posedge ref_clk) disable iff (!rst_n) irq_taken |=> !sleep_request;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not cleared");

  property p_pd_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_pctrl |=> (power_down_request == $past(wd[1]));
  endproperty
  a_pd_write: assert property (p_pd_write) else $error("power-down bit wrong");

  property p_level;
    @(posedge ref_clk) disable iff (!rst_n) wr_high |=> (src_level[11] == $past(wd[5]));
  endproperty
  a_level: assert property (p_level) else $error("level high bit wrong");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_n) (prio_low_q[7:6] == 2'b00) && (prio_high_q[7:6] == 2'b00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits stored");

  property p_baud;
    @(posedge ref_clk) disable iff (!rst_n) (serial_mode == 2'b00) |-> !baud_double_en;
  endproperty
  a_baud: assert property (p_baud) else $error("double rate in mode 0");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_n) (stop_bit_bad && irq_mask_q[0] && !wr_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  ////////////////////////////////////////////////////////////////////////////
  // storage and output checks: a flag must move only for the reason the rules give it, and reads, levels and double rate follow the stored bits

  // software clear of the error flag in the flag view, no new event
  property p_fe_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_ser7 && framing_view_select && !wd[7] && !stop_bit_bad) |=> !framing_error_flag;
  endproperty
  a_fe_clear: assert property (p_fe_clear) else $error("framing flag not cleared");

  // warm resets, reads and idle cycles leave the power-off flag alone
  property p_pof_warm;
    @(posedge ref_clk) disable iff (!cold_rst_n) (!supply_up && !wr_pctrl) |=> $stable(power_off_q);
  endproperty
  a_pof_warm: assert property (p_pof_warm) else $error("power-off flag moved");

  // user flags take the written value
  property p_user_write;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_pctrl |=> (pctrl_q[PCIR_BIT_USER_FLAG_1:PCIR_BIT_USER_FLAG_0] == $past(wd[3:2]));
  endproperty
  a_user_write: assert property (p_user_write) else $error("user flags not written");

  // nothing but a write or a warm reset changes the user flags
  property p_user_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !wr_pctrl |=> $stable(pctrl_q[PCIR_BIT_USER_FLAG_1:PCIR_BIT_USER_FLAG_0]);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user flags changed");

  // priority bits hold between writes
  property p_prio_hold;
    @(posedge ref_clk) disable iff (!rst_n) !(wr_low || wr_high) |=> $stable({prio_high_q, prio_low_q});
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("priority bits changed");

  // low bit of source 0 lands in the bottom of its level
  property p_level_low;
    @(posedge ref_clk) disable iff (!rst_n) wr_low |=> (src_level[0] == $past(wd[0]));
  endproperty
  a_level_low: assert property (p_level_low) else $error("level low bit wrong");

  // power-down request only rises through a register write
  property p_pd_rise;
    @(posedge ref_clk) disable iff (!rst_n) $rose(power_down_request) |-> $past(wr_pctrl);
  endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("power-down set without write");

  // leaving idle on an interrupt is recorded in the status
  property p_wake_evt;
    @(posedge ref_clk) disable iff (!rst_n) (sleep_request && irq_taken) |=> irq_stat_q[PCIR_IRQ_SLEEP];
  endproperty
  a_wake_evt: assert property (p_wake_evt) else $error("wake event lost");

  // a power-down request is recorded in the status
  property p_pd_evt;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_pctrl && wd[PCIR_BIT_POWER_DOWN]) |=> irq_stat_q[PCIR_IRQ_POWERDN];
  endproperty
  a_pd_evt: assert property (p_pd_evt) else $error("power-down event lost");

  // bit 7 window shows the error flag when the view select is set
  property p_view_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd_setup && (paddr == PCIR_ADDR_SER_CTRL7) && framing_view_select) |=> (prdata[7] == $past(fe_q));
  endproperty
  a_view_read: assert property (p_view_read) else $error("framing view read wrong");

  // double rate follows the bit outside the shift-register mode
  property p_baud_on;
    @(posedge ref_clk) disable iff (!rst_n)
      (pctrl_q[PCIR_BIT_BAUD_DOUBLER] && (serial_mode != 2'b00)) |-> baud_double_en;
  endproperty
  a_baud_on: assert property (p_baud_on) else $error("double rate missing");

  c_fe: cover property (@(posedge ref_clk) disable iff (!rst_n) stop_bit_bad ##1 fe_q);
  c_sleep: cover property (@(posedge ref_clk) disable iff (!rst_n) sleep_request ##1 irq_taken);
  c_top: cover property (@(posedge ref_clk) disable iff (!rst_n) src_level[1:0] == 2'b11);
  c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
  c_pof: cover property (@(posedge ref_clk) disable iff (!cold_rst_n) supply_up ##1 power_off_q);

endmodule : pcir_regs

// ---- verif/pcir_tb.sv ----
module testbench
  import pcir_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_n, cold_rst_n, supply_up, irq_taken, stop_bit_bad, serial_mode_bit0;
  logic        psel, penable, pwrite, pready, pslverr, err, irq;
  logic        baud_double_en, framing_view_select, framing_error_flag, power_down_request, sleep_request;
  logic [1:0]  serial_mode;
  logic [3:0]  pstrb;
  logic [11:0] paddr, src_level;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  lo, hi, v;
  int          n_errors, tests_run;
  ////////////////////////////////////////
  // block under test with all six sources
  pcir_regs #(.N_SRC(6)) pcir_regs_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .cold_rst_n(cold_rst_n), .supply_up(supply_up),
    .irq_taken(irq_taken), .stop_bit_bad(stop_bit_bad), .serial_mode(serial_mode),
    .serial_mode_bit0(serial_mode_bit0), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .baud_double_en(baud_double_en), .framing_view_select(framing_view_select),
    .framing_error_flag(framing_error_flag), .power_down_request(power_down_request),
    .sleep_request(sleep_request), .src_level(src_level), .irq(irq));
  // 4 ns period
  always #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  // expected level: high bit weighted above low bit
  function automatic logic [11:0] exp_level(input logic [7:0] h, input logic [7:0] l);
    logic [11:0] r;
    for (int i = 0; i < 6; i++) r[2*i +: 2] = {h[i], l[i]};
    return r;
  endfunction : exp_level
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // one transfer; request held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read and compare; bit 5 of power control is undefined, so masked
  task automatic rdc(input logic [11:0] a, input string s, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(s, e, (a == PCIR_ADDR_POWER_CTRL) ? rd & 32'hdf : rd);
  endtask : rdc
  // one-cycle strobe: 0 warm, 1 cold, 2 supply, 3 irq taken, 4 bad stop bit
  task automatic strobe(input int k);
    @(posedge ref_clk);
    case (k)
      0: rst_n <= 1'b0;
      1: cold_rst_n <= 1'b0;
      2: supply_up <= 1'b1;
      3: irq_taken <= 1'b1;
      default: stop_bit_bad <= 1'b1;
    endcase
    @(posedge ref_clk);
    {rst_n, cold_rst_n, supply_up, irq_taken, stop_bit_bad} <= 5'b11000;
  endtask : strobe
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  // hang guard, well above the few hundred cycles needed
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    {ref_clk, rst_n, cold_rst_n, supply_up, irq_taken, stop_bit_bad, serial_mode_bit0} = 7'h0;
    {psel, penable, pwrite, paddr, pwdata, serial_mode} = '0;
    pstrb = 4'hf;
    void'($urandom(1));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    cold_rst_n <= 1'b1;
    rdc(PCIR_ADDR_POWER_CTRL, "pctrl_rst", {24'h0, PCIR_PCTRL_RESET});
    rdc(PCIR_ADDR_PRIO_LOW, "prio_low_rst", 32'h0);
    rdc(PCIR_ADDR_PRIO_HIGH, "prio_high_rst", 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lo = (i == 0) ? 8'h15 : 8'($urandom) & PCIR_PRIO_WMASK;
      hi = (i == 0) ? 8'h2a : 8'($urandom) & PCIR_PRIO_WMASK;
      apb(PCIR_ADDR_PRIO_LOW, 1'b1, {24'h0, lo});
      apb(PCIR_ADDR_PRIO_HIGH, 1'b1, {24'h0, hi});
      rdc(PCIR_ADDR_PRIO_LOW, "prio_low", {24'h0, lo});
      rdc(PCIR_ADDR_PRIO_HIGH, "prio_high", {24'h0, hi});
      chk("src_level", {20'h0, exp_level(hi, lo)}, {20'h0, src_level});
      if (i == 0) chk("code_order", 32'h1, {31'h0, src_level[3:2] > src_level[1:0]});
    end
    $display("test priority done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) & PCIR_PCTRL_WMASK;
      serial_mode <= 2'(i);
      apb(PCIR_ADDR_POWER_CTRL, 1'b1, {24'h0, v});
      rdc(PCIR_ADDR_POWER_CTRL, "pctrl", {24'h0, v});
      chk("baud", {31'h0, v[7] && i != 0}, {31'h0, baud_double_en});
      chk("view", {31'h0, v[6]}, {31'h0, framing_view_select});
      chk("pd_idle", {30'h0, v[1:0]}, {30'h0, power_down_request, sleep_request});
    end
    $display("test power control done");
    apb(PCIR_ADDR_POWER_CTRL, 1'b1, 32'h1f);
    strobe(0);
    rdc(PCIR_ADDR_POWER_CTRL, "warm_keep", 32'h10);
    apb(PCIR_ADDR_POWER_CTRL, 1'b1, 32'h0);
    strobe(0);
    rdc(PCIR_ADDR_POWER_CTRL, "warm_zero", 32'h0);
    strobe(2);
    rdc(PCIR_ADDR_POWER_CTRL, "supply", 32'h10);
    apb(PCIR_ADDR_POWER_CTRL, 1'b1, 32'h0);
    strobe(1);
    rdc(PCIR_ADDR_POWER_CTRL, "cold", 32'h10);
    apb(PCIR_ADDR_POWER_CTRL, 1'b1, 32'h11);
    strobe(3);
    rdc(PCIR_ADDR_POWER_CTRL, "wake", 32'h10);
    rdc(PCIR_ADDR_IRQ_STATUS, "status_wake", 32'h4);
    $display("test resets done");
    // framing error path and its interrupt; irq sampled after a settled edge
    apb(PCIR_ADDR_POWER_CTRL, 1'b1, 32'h50);
    apb(PCIR_ADDR_IRQ_MASK, 1'b1, 32'h0);
    apb(PCIR_ADDR_IRQ_STATUS, 1'b1, 32'h7);
    strobe(4);
    rdc(PCIR_ADDR_SER_CTRL7, "fe_view", 32'h80);
    rdc(PCIR_ADDR_IRQ_STATUS, "status", 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(PCIR_ADDR_IRQ_MASK, 1'b1, 32'h1);
    @(posedge ref_clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(PCIR_ADDR_IRQ_STATUS, 1'b1, 32'h1);
    rdc(PCIR_ADDR_IRQ_STATUS, "status_clr", 32'h0);
    chk("irq_off", 32'h0, {31'h0, irq});
    chk("fe_sticky", 32'h1, {31'h0, framing_error_flag});
    apb(PCIR_ADDR_SER_CTRL7, 1'b1, 32'h0);
    rdc(PCIR_ADDR_SER_CTRL7, "fe_clr", 32'h0);
    serial_mode_bit0 <= 1'b1;
    apb(PCIR_ADDR_POWER_CTRL, 1'b1, 32'h10);
    rdc(PCIR_ADDR_SER_CTRL7, "mode_view", 32'h80);
    apb(12'hffc, 1'b0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    // bad stop bit with the mask open raises the interrupt one edge later
    strobe(4);
    @(posedge ref_clk);
    chk("irq_event", 32'h1, {31'h0, irq});
    $display("test framing and irq done");
    finish_test();
  end
endmodule : testbench
